// ### rtl/osc_det_pkg.sv
package osc_det_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Each register index is a word index; the bus byte address is four times it.
  localparam logic [15:0] IDX_ENABLE_CODE = 16'h1f7c;
  localparam logic [15:0] IDX_LOWER       = 16'h1f7d;
  localparam logic [15:0] IDX_UPPER       = 16'h1f7e;
  localparam logic [15:0] IDX_KEY         = 16'h1f7f;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'h1f80;
  localparam logic [15:0] IDX_IRQ_CLEAR   = 16'h1f81;
  localparam logic [15:0] IDX_IRQ_ENABLE  = 16'h1f82;
  localparam logic [15:0] IDX_STATE       = 16'h1f83;

  // ==========================================================================
  // Codes and reset values
  // ==========================================================================
  localparam logic [7:0] KEY_UNLOCK  = 8'hf9;
  localparam logic [7:0] KEY_LOCK    = 8'h06;
  localparam logic [7:0] CODE_OFF    = 8'h00;
  localparam logic [7:0] CODE_ON     = 8'he4;
  localparam logic [7:0] RST_KEY     = KEY_LOCK;
  localparam logic [7:0] RST_CODE    = CODE_OFF;
  localparam logic [7:0] RST_LOWER   = 8'h20;
  localparam logic [7:0] RST_UPPER   = 8'h40;

  // ==========================================================================
  // Interrupt status layout
  // ==========================================================================
  localparam int IRQ_W       = 4;
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_STOP    = 1;
  localparam int IRQ_RELEASE = 2;
  localparam int IRQ_BLOCKED = 3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WINDOW_NS       = 3200;
  localparam int WINDOW_CYCLES   = WINDOW_NS / CLK_PERIOD_NS;
  localparam int QUALIFY_WINDOWS = 4;
  localparam int COUNT_W         = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_QUAL_BAD  = 2'b01,
    ST_FAULT     = 2'b11,
    ST_QUAL_GOOD = 2'b10
  } det_state_t;

endpackage : osc_det_pkg

// ### rtl/meas_if.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Frequency measurement result
// ============================================================================
interface meas_if #(
  parameter int CW = 8
);
  logic [CW-1:0] count;
  logic          done;

  modport meter (output count, output done);
  modport user  (input count, input done);
endinterface : meas_if

`default_nettype wire

// ### rtl/osc_meter.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Oscillator edge counter over a fixed reference window
// ============================================================================
module osc_meter
  import osc_det_pkg::*;
#(
  parameter int WINDOW = WINDOW_CYCLES
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic osc_pin,
  meas_if.meter     m
);

  localparam int WW = $clog2(WINDOW + 1);

  logic [2:0]         sync_r;
  logic               level_r;
  logic [WW-1:0]      win_r;
  logic [COUNT_W-1:0] edges_r;
  logic [COUNT_W-1:0] edges_nxt;
  logic [COUNT_W-1:0] count_r;
  logic               done_r;
  wire                stable;
  wire                rise;

  // A level counts only once the second and third stages agree.
  assign stable    = sync_r[1] == sync_r[2];
  assign rise      = stable & sync_r[2] & ~level_r;
  // Saturation keeps a runaway oscillator reading as too fast, never wrapped.
  assign edges_nxt = (rise && edges_r != '1) ? edges_r + 1'b1 : edges_r;
  assign m.count   = count_r;
  assign m.done    = done_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_r  <= 3'h0;
      level_r <= 1'b0;
      win_r   <= WW'(WINDOW - 1);
      edges_r <= '0;
      count_r <= '0;
      done_r  <= 1'b0;
    end
    else if (ce)
    begin
      sync_r <= {sync_r[1:0], osc_pin};
      if (stable)
        level_r <= sync_r[2];
      done_r <= 1'b0;
      if (win_r == '0)
      begin
        win_r   <= WW'(WINDOW - 1);
        count_r <= edges_nxt; // see RQ17
        edges_r <= '0;
        done_r  <= 1'b1;
      end
      else
      begin
        win_r   <= win_r - 1'b1;
        edges_r <= edges_nxt;
      end
    end
  end

endmodule : osc_meter

`default_nettype wire

// ### rtl/osc_freq_detector.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RQ1 - Raise the I/O reset when oscillator runs below lower or above upper limit.
// RQ2 - External reset loads lower limit 20h (10MHz) and upper 40h (20MHz).
// RQ3 - Threshold writes land only while detection is off and key holds F9h.
// RQ4 - Threshold writes while enabled or locked with 06h are discarded.
// RQ5 - Detection starts off; software unlocks with F9h then writes E4h to enable.
// RQ6 - While detection reset is active, ordinary I/O pins are forced high impedance.
// RQ7 - A stop-caused detection reset holds internal state instead of initialising it.
// RQ8 - Detection works in normal and idle modes and is suppressed in stop mode.
// RQ9 - Key takes F9h to unlock, 06h to lock; any other value becomes 06h.
// RQ10 - Control code 00h disables, E4h enables; other codes written are ignored.
// RQ11 - Control code and both thresholds always read back whatever the key holds.
// RQ12 - Thresholds survive every internal reset; only the external reset initialises them.
// RQ13 - Software keeps the lower threshold strictly below the upper threshold.
// RQ14 - Software keeps both detection frequencies within 8MHz to 20MHz.
// RQ15 - Key and control code are initialised only by the external reset.
// RQ16 - Reset asserts after bad frequency persists, releases after good persists.
// RQ17 - Frequency is an edge count over a reference window, compared with thresholds.
module osc_freq_detector
  import osc_det_pkg::*;
#(
  parameter int WINDOW  = WINDOW_CYCLES,
  parameter int QUALIFY = QUALIFY_WINDOWS
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        osc_input_pin,
  input  wire logic        stop_mode,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             det_reset,
  output logic             io_hiz,
  output logic             state_hold,
  output logic             irq
);

  localparam int QW = $clog2(QUALIFY + 1);

  // ==========================================================================
  // Frequency measurement
  // ==========================================================================
  meas_if #(.CW(COUNT_W)) meas ();

  osc_meter #(
    .WINDOW (WINDOW)
  ) u_meter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .osc_pin (osc_input_pin),
    .m       (meas)
  );

  // ==========================================================================
  // Register bus, write path
  // ==========================================================================
  logic             aw_hold_r;
  logic [15:0]      awaddr_r;
  logic             w_hold_r;
  logic [7:0]       wbyte_r;
  logic             wstrb0_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [1:0]       rresp_r;
  logic [31:0]      rdata_r;

  logic [7:0]       key_r;
  logic [7:0]       code_r;
  logic [7:0]       lower_r;
  logic [7:0]       upper_r;
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic             irq_r;

  det_state_t       st_r;
  det_state_t       st_nxt;
  logic [QW-1:0]    cnt_r;
  logic [QW-1:0]    cnt_nxt;
  logic             stop_r;
  logic             stop_nxt;
  logic             det_r;

  wire do_write = ce & aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_en    = do_write & wstrb0_r;

  wire w_code   = awaddr_r[15:2] == IDX_ENABLE_CODE[13:0];
  wire w_lower  = awaddr_r[15:2] == IDX_LOWER[13:0];
  wire w_upper  = awaddr_r[15:2] == IDX_UPPER[13:0];
  wire w_key    = awaddr_r[15:2] == IDX_KEY[13:0];
  wire w_stat   = awaddr_r[15:2] == IDX_IRQ_STATUS[13:0];
  wire w_clr    = awaddr_r[15:2] == IDX_IRQ_CLEAR[13:0];
  wire w_ien    = awaddr_r[15:2] == IDX_IRQ_ENABLE[13:0];
  wire w_state  = awaddr_r[15:2] == IDX_STATE[13:0];
  wire w_hit    = w_code | w_lower | w_upper | w_key | w_stat | w_clr | w_ien | w_state;

  wire unlocked = key_r == KEY_UNLOCK;
  wire code_ok  = (wbyte_r == CODE_OFF) || (wbyte_r == CODE_ON);
  // Thresholds move only while detection is off and the key is open.
  wire thr_ok   = unlocked & (code_r != CODE_ON); // see RQ3
  wire thr_try  = wr_en & (w_lower | w_upper);
  wire blocked  = thr_try & ~thr_ok; // see RQ4

  assign awready = ce & ~aw_hold_r & ~bvalid_r;
  assign wready  = ce & ~w_hold_r & ~bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 16'h0000;
      w_hold_r  <= 1'b0;
      wbyte_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        wbyte_r  <= wdata[7:0];
        wstrb0_r <= wstrb[0];
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Protected configuration registers
  // ==========================================================================
  // Only aresetn (the external reset) clears these; the detection reset and
  // other internal resets never reach them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_r   <= RST_KEY;   // see RQ15
      code_r  <= RST_CODE;  // see RQ5
      lower_r <= RST_LOWER; // see RQ2
      upper_r <= RST_UPPER; // see RQ12
    end
    else if (ce)
    begin
      if (wr_en && w_key)
        key_r <= (wbyte_r == KEY_UNLOCK) ? KEY_UNLOCK : KEY_LOCK; // see RQ9
      if (wr_en && w_code && unlocked && code_ok)
        code_r <= wbyte_r; // see RQ10
      if (thr_try && thr_ok && w_lower)
        lower_r <= wbyte_r;
      if (thr_try && thr_ok && w_upper)
        upper_r <= wbyte_r;
    end
  end

  // ==========================================================================
  // Detection state machine
  // ==========================================================================
  // Stop mode covers its warm-up too, so detection resumes only afterwards.
  wire detect_on = (code_r == CODE_ON) & ~stop_mode; // see RQ8
  wire stopped   = meas.count == '0;
  wire bad       = (meas.count < lower_r) | (meas.count > upper_r); // see RQ1
  wire last_qual = cnt_r == QW'(QUALIFY - 1);
  wire det_nxt   = (st_nxt == ST_FAULT) | (st_nxt == ST_QUAL_GOOD);

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    stop_nxt = stop_r;
    if (!detect_on)
    begin
      st_nxt   = ST_RUN;
      cnt_nxt  = '0;
      stop_nxt = 1'b0;
    end
    else if (meas.done)
    begin
      case (st_r)
        ST_RUN, ST_QUAL_BAD:
        begin
          if (!bad)
          begin
            st_nxt  = ST_RUN;
            cnt_nxt = '0;
          end
          else if (last_qual)
          begin
            st_nxt   = ST_FAULT; // see RQ16
            cnt_nxt  = '0;
            stop_nxt = stopped;
          end
          else
          begin
            st_nxt  = ST_QUAL_BAD;
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        default:
        begin
          if (bad)
          begin
            st_nxt   = ST_FAULT;
            cnt_nxt  = '0;
            stop_nxt = stop_r | stopped;
          end
          else if (last_qual)
          begin
            st_nxt   = ST_RUN; // see RQ16
            cnt_nxt  = '0;
            stop_nxt = 1'b0;
          end
          else
          begin
            st_nxt  = ST_QUAL_GOOD;
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r   <= ST_RUN;
      cnt_r  <= '0;
      stop_r <= 1'b0;
      det_r  <= 1'b0;
    end
    else if (ce)
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      stop_r <= stop_nxt;
      det_r  <= det_nxt;
    end
  end

  assign det_reset  = det_r;
  assign io_hiz     = det_r; // see RQ6
  // The core must treat this as a freeze, not an initialising reset.
  assign state_hold = det_r & stop_r; // see RQ7

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] status_nxt;
  logic [IRQ_W-1:0] irq_en_nxt;

  always_comb
  begin
    ev              = '0;
    ev[IRQ_FAULT]   = det_nxt & ~det_r;
    ev[IRQ_STOP]    = det_nxt & ~det_r & stop_nxt;
    ev[IRQ_RELEASE] = ~det_nxt & det_r;
    ev[IRQ_BLOCKED] = blocked;
    clr             = (wr_en && w_clr) ? wbyte_r[IRQ_W-1:0] : '0;
    // A new event in the clearing cycle survives the clear.
    status_nxt      = (status_r & ~clr) | ev;
    irq_en_nxt      = (wr_en && w_ien) ? wbyte_r[IRQ_W-1:0] : irq_en_r;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r <= '0;
      irq_en_r <= '0;
      irq_r    <= 1'b0;
    end
    else if (ce)
    begin
      status_r <= status_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r    <= |(status_nxt & irq_en_nxt);
    end
  end

  assign irq = irq_r;

  // ==========================================================================
  // Register bus, read path
  // ==========================================================================
  wire [13:0] ra      = araddr[15:2];
  wire        r_code  = ra == IDX_ENABLE_CODE[13:0];
  wire        r_lower = ra == IDX_LOWER[13:0];
  wire        r_upper = ra == IDX_UPPER[13:0];
  wire        r_key   = ra == IDX_KEY[13:0];
  wire        r_stat  = ra == IDX_IRQ_STATUS[13:0];
  wire        r_clr   = ra == IDX_IRQ_CLEAR[13:0];
  wire        r_ien   = ra == IDX_IRQ_ENABLE[13:0];
  wire        r_state = ra == IDX_STATE[13:0];
  wire        r_hit   = r_code | r_lower | r_upper | r_key | r_stat | r_clr | r_ien | r_state;

  wire [31:0] state_word = {16'h0000, meas.count, 3'h0, detect_on, st_r, stop_r, det_r};

  // Readback ignores the key entirely; only writes are protected.
  wire [31:0] rd_mux =
    r_code  ? {24'h000000, code_r}  : // see RQ11
    r_lower ? {24'h000000, lower_r} :
    r_upper ? {24'h000000, upper_r} :
    r_key   ? {24'h000000, key_r}   :
    r_stat  ? {28'h0000000, status_r} :
    r_ien   ? {28'h0000000, irq_en_r} :
    r_state ? state_word :
    32'h00000000;

  assign arready = ce & ~rvalid_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_mux;
      end
      else if (rvalid_r && rready)
        rvalid_r <= 1'b0;
    end
  end

endmodule : osc_freq_detector

`default_nettype wire

// ### tb/osc_det_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Bus handshake and detection output checks
// ============================================================================
module osc_det_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        stop_mode,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        det_reset,
  input wire logic        io_hiz,
  input wire logic        state_hold,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence ar_taken;
    arvalid && arready;
  endsequence
  sequence r_stalled;
    rvalid && !rready;
  endsequence

  chk_read_answer: assert property (ar_taken |=> rvalid)
    else $error("read answer missing");
  chk_read_stall: assert property (r_stalled |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed while stalled");
  chk_write_stall: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer changed while stalled");
  chk_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  chk_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  chk_hiz_follows: assert property (io_hiz == det_reset)
    else $error("pin release differs from detection reset");
  chk_hold_cause: assert property (state_hold |-> det_reset)
    else $error("state hold without detection reset");
  chk_stop_release: assert property (stop_mode && ce |=> !det_reset)
    else $error("detection reset active in stop mode");
  chk_reset_clear: assert property ($rose(aresetn) |-> !det_reset && !irq && !bvalid && !rvalid)
    else $error("outputs not cleared by external reset");
endmodule : osc_det_monitor

bind osc_freq_detector osc_det_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .stop_mode(stop_mode), .awready(awready),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .det_reset(det_reset), .io_hiz(io_hiz), .state_hold(state_hold), .irq(irq)
);

`default_nettype wire

// ### tb/osc_freq_detector_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module osc_freq_detector_tb_top
  import osc_det_pkg::*;
;
  localparam int WIN  = 40;
  localparam int QUAL = 2;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        osc_input_pin = 1'b0;
  logic        stop_mode = 1'b0;
  logic [15:0] awaddr  = 16'h0000;
  logic [15:0] araddr  = 16'h0000;
  logic [31:0] wdata   = 32'h00000000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [31:0] rnd_r   = 32'hcc5d;
  logic        awready, wready, bvalid, arready, rvalid, det_reset, io_hiz, state_hold, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, r;
  int          failures = 0, checks_done = 0, osc_half = 3, osc_cnt = 0;
  int          key_m, code_m, lo_m, hi_m, st_m, en_m;

  osc_freq_detector #(.WINDOW(WIN), .QUALIFY(QUAL)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .osc_input_pin(osc_input_pin),
    .stop_mode(stop_mode), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .det_reset(det_reset), .io_hiz(io_hiz), .state_hold(state_hold), .irq(irq));

  initial forever #5 aclk = ~aclk;

  // Half period zero stands the oscillator still, as a stopped crystal would.
  // The pin filter wants two equal samples, so a half period below 2 reads as stopped.
  always @(posedge aclk)
  begin
    if (osc_half == 0)
      osc_input_pin <= 1'b0;
    else if (osc_cnt + 1 >= osc_half)
    begin
      osc_cnt <= 0;
      osc_input_pin <= ~osc_input_pin;
    end
    else
      osc_cnt <= osc_cnt + 1;
  end

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    rnd_r = rnd_r ^ (rnd_r << 13);
    rnd_r = rnd_r ^ (rnd_r >> 17);
    rnd_r = rnd_r ^ (rnd_r << 5);
    return rnd_r;
  endfunction : xs

  // ==========================================================================
  // Register model
  // ==========================================================================
  task automatic reset_model;
    key_m = RST_KEY;
    code_m = RST_CODE;
    lo_m = RST_LOWER;
    hi_m = RST_UPPER;
    st_m = 0;
    en_m = 0;
  endtask : reset_model

  function automatic logic [1:0] model_wr(input logic [15:0] idx, input logic [7:0] v);
    logic ok;
    ok = (key_m == KEY_UNLOCK);
    case (idx)
      IDX_KEY: key_m = (v == KEY_UNLOCK) ? KEY_UNLOCK : KEY_LOCK;
      IDX_ENABLE_CODE: if (ok && (v == CODE_OFF || v == CODE_ON)) code_m = v;
      IDX_LOWER, IDX_UPPER:
        if (ok && code_m != CODE_ON)
        begin
          lo_m = (idx == IDX_LOWER) ? v : lo_m;
          hi_m = (idx == IDX_UPPER) ? v : hi_m;
        end
        else
          st_m = st_m | 8;
      IDX_IRQ_CLEAR: st_m = st_m & ~int'(v);
      IDX_IRQ_ENABLE: en_m = v & 8'h0f;
      IDX_IRQ_STATUS, IDX_STATE: ;
      default: return RESP_SLVERR;
    endcase
    return RESP_OKAY;
  endfunction : model_wr

  function automatic logic [31:0] model_rd(input logic [15:0] idx);
    case (idx)
      IDX_KEY: return 32'(key_m);
      IDX_ENABLE_CODE: return 32'(code_m);
      IDX_LOWER: return 32'(lo_m);
      IDX_UPPER: return 32'(hi_m);
      IDX_IRQ_STATUS: return 32'(st_m);
      IDX_IRQ_ENABLE: return 32'(en_m);
      default: return 32'h00000000;
    endcase
  endfunction : model_rd

  // ==========================================================================
  // Bus master
  // ==========================================================================
  task automatic bus_wr(input logic [15:0] idx, input logic [7:0] val);
    int n;
    n = 0;
    r = xs();
    @(posedge aclk);
    awaddr <= {idx[13:0], 2'b00};
    wdata <= {r[23:0], val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= r[24];
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 50);
    bready <= 1'b0;
    check(32'(bvalid), 32'h1);
    check(32'(bresp), 32'(model_wr(idx, val)));
    if (n >= 50) end_sim();
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] idx);
    int n;
    n = 0;
    r = xs();
    @(posedge aclk);
    araddr <= {idx[13:0], 2'b00};
    arvalid <= 1'b1;
    rready <= r[0];
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready) && n < 50);
    rready <= 1'b0;
    check(32'(rvalid), 32'h1);
    check(rdata, model_rd(idx));
    check(32'(rresp), (idx >= IDX_ENABLE_CODE && idx <= IDX_STATE) ? 32'(RESP_OKAY) : 32'h2);
    if (n >= 50) end_sim();
  endtask : bus_rd

  task automatic wait_det(input logic lvl);
    int n;
    n = 0;
    while (det_reset !== lvl && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    check(32'(det_reset), 32'(lvl));
    if (n >= 300) end_sim();
  endtask : wait_det

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    reset_model();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) bus_rd(IDX_ENABLE_CODE + 16'(i));
    bus_wr(IDX_LOWER, 8'h11);
    bus_rd(IDX_LOWER);
    bus_wr(16'h0100, 8'h00);
    bus_rd(16'h0100);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      bus_wr(IDX_KEY, (r[7:0] == KEY_UNLOCK) ? 8'h07 : r[7:0]);
      bus_rd(IDX_KEY);
    end
    bus_wr(IDX_KEY, KEY_UNLOCK);
    bus_wr(IDX_ENABLE_CODE, 8'h5a);
    bus_rd(IDX_ENABLE_CODE);
    bus_wr(IDX_LOWER, 8'h04);
    bus_wr(IDX_UPPER, 8'h08);
    bus_wr(IDX_KEY, KEY_LOCK);
    bus_rd(IDX_LOWER);
    bus_rd(IDX_UPPER);
    bus_wr(IDX_KEY, KEY_UNLOCK);
    bus_wr(IDX_ENABLE_CODE, CODE_ON);
    bus_rd(IDX_ENABLE_CODE);
    bus_wr(IDX_UPPER, 8'h33);
    bus_rd(IDX_UPPER);
    $display("test register access done");
    osc_half <= 0;
    repeat (35) @(posedge aclk);
    check(32'(det_reset), 32'h0);
    wait_det(1'b1);
    check(32'(state_hold), 32'h1);
    check(32'(io_hiz), 32'h1);
    bus_rd(IDX_LOWER);
    st_m = st_m | 3;
    osc_half <= 3;
    repeat (35) @(posedge aclk);
    check(32'(det_reset), 32'h1);
    wait_det(1'b0);
    st_m = st_m | 4;
    osc_half <= 2;
    wait_det(1'b1);
    check(32'(state_hold), 32'h0);
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(det_reset), 32'h0);
    $display("test detection done");
    bus_rd(IDX_IRQ_STATUS);
    check(32'(irq), 32'h0);
    bus_wr(IDX_IRQ_ENABLE, 8'h01);
    bus_rd(IDX_IRQ_ENABLE);
    check(32'(irq), 32'h1);
    bus_wr(IDX_IRQ_CLEAR, 8'h01);
    bus_rd(IDX_IRQ_STATUS);
    check(32'(irq), 32'h0);
    $display("test interrupt done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    for (int i = 0; i < 4; i++) bus_rd(IDX_ENABLE_CODE + 16'(i));
    $display("test external reset done");
    end_sim();
  end
endmodule : osc_freq_detector_tb_top

`default_nettype wire
